// file: rtl/rtcit_pkg.sv
package rtcit_pkg;
  // ****************************************
  // Timing, in the units of the printed figures
  // ****************************************
  localparam int CLK_NS = 20;
  localparam int RTN_FAST_NS = 122000;
  localparam int RTN_SLOW_NS = 7810000;
  localparam int TEST_PERIOD_NS = 15625000;
  localparam int CNT_W = 20;
  // Half-period shift per trim code, times four
  localparam int TRIM_STEP_X4 = 305;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_TRIM = 8'h08;
  localparam logic [7:0] OFS_ALM0 = 8'h0C;
  localparam logic [7:0] OFS_ALM1 = 8'h10;
  localparam logic [7:0] OFS_TIME0 = 8'h14;
  localparam logic [7:0] OFS_TIME1 = 8'h18;
  localparam logic [7:0] OFS_ISTAT = 8'h1C;
  localparam logic [7:0] OFS_IMASK = 8'h20;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_AIE = 0;
  localparam int CTRL_TIE = 1;
  localparam int CTRL_STYLE = 2;
  localparam int CTRL_FE = 3;
  localparam int CTRL_BYP = 4;
  localparam int CTRL_TEN = 5;
  localparam int CTRL_TEST = 6;
  localparam int CTRL_SRC = 8;
  localparam int FLG_ALARM = 0;
  localparam int FLG_TIMER = 1;
  localparam int ALM_SEC = 0;
  localparam int ALM_MIN = 8;
  localparam int ALM_HOUR = 16;
  localparam int ALM_WDAY = 24;
  localparam int ALM_DAY = 0;
  localparam int EN_SEC = 8;
  localparam int EN_MIN = 9;
  localparam int EN_HOUR = 10;
  localparam int EN_WDAY = 11;
  localparam int EN_DAY = 12;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [2:0] WDAY_LAST = 3'h6;
  // Pin idle levels: select high, high enable low, low enable high
  localparam logic [2:0] PIN_RST = 3'h5;

  typedef enum logic [1:0] {
    SRC_4096,
    SRC_64,
    SRC_1,
    SRC_MIN
  } rtcit_src_t;
endpackage

// file: rtl/rtcit_cnt_if.sv
`timescale 1ns/1ns
`default_nettype none
interface rtcit_cnt_if;
  logic load;
  logic [rtcit_pkg::CNT_W-1:0] count;
  logic busy;
  logic done;
  modport ctl (output load, output count, input busy, input done);
  modport cnt (input load, input count, output busy, output done);
endinterface
`default_nettype wire

// file: rtl/rtcit_countdown.sv
`timescale 1ns/1ns
`default_nettype none
module rtcit_countdown (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  rtcit_cnt_if.cnt c
);
  import rtcit_pkg::*;

  logic [CNT_W-1:0] cnt_reg;

  // Busy for count+1 cycles after a load
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
    end else if (c.load) begin
      cnt_reg <= c.count + CNT_W'(1);
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - CNT_W'(1);
    end
  end

  assign c.busy = (cnt_reg != '0);
  assign c.done = (cnt_reg == CNT_W'(1));
endmodule
`default_nettype wire

// file: rtl/rtcit_top.sv
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Alarm enable set and alarm flag set pulls alarm request low.
// - Alarm enable clear leaves alarm request undriven.
// - Alarm is checked on the seconds-to-minutes carry.
// - Timer style bit: 0 level, 1 periodic.
// - Level style: enable and timer flag pull timer request low.
// - Timer enable clear leaves timer request undriven in any style.
// - Periodic style: event pulls low if enabled; flag set anyway.
// - Periodic pulse ends after 0.122ms or 7.81ms by source.
// - Alarm compares day, weekday, hour, minute, second; one weekday.
// - Writing 0 to alarm flag rearms alarm detection.
// - Alarm flag sets on match even with enable clear.
// - Weekday codes 0 to 6; after 6 comes 0.
// - Hour, minute, second alarm fields are BCD, 24-hour.
// - Chip enables active, test and trim enable bits set give corrected 64Hz output; driven when selected and enabled.
// - Test output deviation is trim value times 195.2 ppm.
// - Low enable rising clears the test bit and ends test mode.
module rtcit_top #(
  parameter int RTN_FAST_CYC = rtcit_pkg::RTN_FAST_NS / rtcit_pkg::CLK_NS,
  parameter int RTN_SLOW_CYC = rtcit_pkg::RTN_SLOW_NS / rtcit_pkg::CLK_NS,
  parameter int TEST_HALF_CYC =
    rtcit_pkg::TEST_PERIOD_NS / rtcit_pkg::CLK_NS / 2
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Clock counters, same clock
  input wire logic [6:0] time_sec,
  input wire logic [6:0] time_min,
  input wire logic [5:0] time_hour,
  input wire logic [2:0] time_wday,
  input wire logic [5:0] time_day,
  input wire logic sec_carry,
  input wire logic timer_tick,
  // Pins
  input wire logic chip_enable_low_pin_n,
  input wire logic chip_enable_high_pin,
  input wire logic output_select_pin,
  output logic alarm_request_pin_o,
  output logic alarm_request_pin_oe,
  output logic timer_request_pin_o,
  output logic timer_request_pin_oe,
  output logic freq_output_pin_o,
  output logic freq_output_pin_oe,
  // Interrupt
  output logic irq
);
  import rtcit_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic cel_n;
  logic ceh;
  logic fsel;
  logic cel_n_d_reg;
  logic cel_rise;
  logic wr_en_reg;
  logic [7:0] wr_addr_reg;
  logic rd_take;
  logic [31:0] rd_data;
  logic [31:0] ctrl_reg;
  logic [6:0] trim_reg;
  logic [31:0] alm0_reg;
  logic [31:0] alm1_reg;
  logic [1:0] flag_reg;
  logic [1:0] flag_next;
  logic [1:0] istat_reg;
  logic [1:0] imask_reg;
  logic armed_reg;
  logic alarm_match;
  logic alarm_hit;
  logic alarm_irq_enable;
  logic timer_irq_enable;
  logic periodic;
  logic test_on;
  logic tst_fire;
  logic trq_next;
  logic [2:0] wday_wr;
  logic signed [7:0] trim_s;
  logic signed [CNT_W:0] adj;
  rtcit_src_t src;

  rtcit_cnt_if rtn_if ();
  rtcit_cnt_if tst_if ();

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_reg <= PIN_RST;
      pin_s2_reg <= PIN_RST;
      cel_n_d_reg <= 1'b1;
    end else begin
      pin_s1_reg <= {output_select_pin, chip_enable_high_pin,
                     chip_enable_low_pin_n};
      pin_s2_reg <= pin_s1_reg;
      cel_n_d_reg <= pin_s2_reg[0];
    end
  end

  assign cel_n = pin_s2_reg[0];
  assign ceh = pin_s2_reg[1];
  assign fsel = pin_s2_reg[2];
  assign cel_rise = cel_n & ~cel_n_d_reg;

  // ****************************************
  // Bus slave
  // ****************************************
  assign rd_take = hsel & htrans[1] & hready & ~hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_en_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (hready) begin
      wr_en_reg <= hsel & htrans[1] & hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  // Zero wait states; errors are never signalled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (haddr[7:0])
      OFS_CTRL: rd_data = ctrl_reg;
      OFS_FLAGS: rd_data = {30'h0, flag_reg};
      OFS_TRIM: rd_data = {25'h0, trim_reg};
      OFS_ALM0: rd_data = alm0_reg;
      OFS_ALM1: rd_data = alm1_reg;
      OFS_TIME0: rd_data = {5'h0, time_wday, 2'h0, time_hour,
                            1'b0, time_min, 1'b0, time_sec};
      OFS_TIME1: rd_data = {26'h0, time_day};
      OFS_ISTAT: rd_data = {30'h0, istat_reg};
      OFS_IMASK: rd_data = {30'h0, imask_reg};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Read data is caught at the address phase edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata <= rd_data;
    end
  end

  // ****************************************
  // Control and alarm registers
  // ****************************************
  // Out-of-range weekday folds back onto the 0..6 cycle
  assign wday_wr = (hwdata[ALM_WDAY +: 3] > WDAY_LAST) ?
                   3'h0 : hwdata[ALM_WDAY +: 3];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= REG_RST;
    end else begin
      if (wr_en_reg && wr_addr_reg == OFS_CTRL) begin
        ctrl_reg <= hwdata & 32'h0000_037F;
      end
      if (cel_rise) begin
        ctrl_reg[CTRL_TEST] <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trim_reg <= REG_RST[6:0];
    end else if (wr_en_reg && wr_addr_reg == OFS_TRIM) begin
      trim_reg <= hwdata[6:0];
    end
  end

  // BCD fields kept at counter width
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alm0_reg <= REG_RST;
      alm1_reg <= REG_RST;
    end else begin
      if (wr_en_reg && wr_addr_reg == OFS_ALM0) begin
        alm0_reg <= {5'h0, wday_wr, 2'h0, hwdata[ALM_HOUR +: 6],
                     1'b0, hwdata[ALM_MIN +: 7],
                     1'b0, hwdata[ALM_SEC +: 7]};
      end
      if (wr_en_reg && wr_addr_reg == OFS_ALM1) begin
        alm1_reg <= {19'h0, hwdata[EN_DAY:EN_SEC],
                     2'h0, hwdata[ALM_DAY +: 6]};
      end
    end
  end

  assign alarm_irq_enable = ctrl_reg[CTRL_AIE];
  assign timer_irq_enable = ctrl_reg[CTRL_TIE];
  assign periodic = ctrl_reg[CTRL_STYLE];
  assign src = rtcit_src_t'(ctrl_reg[CTRL_SRC +: 2]);

  // ****************************************
  // Alarm detection
  // ****************************************
  // Weekday compares one stored code only
  assign alarm_match =
    (!alm1_reg[EN_SEC] || alm0_reg[ALM_SEC +: 7] == time_sec) &&
    (!alm1_reg[EN_MIN] || alm0_reg[ALM_MIN +: 7] == time_min) &&
    (!alm1_reg[EN_HOUR] || alm0_reg[ALM_HOUR +: 6] == time_hour) &&
    (!alm1_reg[EN_WDAY] || alm0_reg[ALM_WDAY +: 3] == time_wday) &&
    (!alm1_reg[EN_DAY] || alm1_reg[ALM_DAY +: 6] == time_day) &&
    (alm1_reg[EN_DAY:EN_SEC] != 5'h00);

  // Checked only on the carry into minutes; enable plays no part
  assign alarm_hit = sec_carry & armed_reg & alarm_match;

  // A match fires once; a written 0 to the flag arms it again
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_reg <= 1'b0;
    end else if (wr_en_reg && wr_addr_reg == OFS_FLAGS &&
                 !hwdata[FLG_ALARM]) begin
      armed_reg <= 1'b1;
    end else if (alarm_hit) begin
      armed_reg <= 1'b0;
    end
  end

  // ****************************************
  // Event flags
  // ****************************************
  // Event wins over a clear in the same cycle
  always_comb begin
    flag_next = flag_reg;
    if (wr_en_reg && wr_addr_reg == OFS_FLAGS) begin
      flag_next = flag_reg & hwdata[1:0];
    end
    if (alarm_hit) begin
      flag_next[FLG_ALARM] = 1'b1;
    end
    if (timer_tick) begin
      flag_next[FLG_TIMER] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_reg <= 2'b00;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      istat_reg <= 2'b00;
    end else begin
      if (wr_en_reg && wr_addr_reg == OFS_ISTAT) begin
        istat_reg <= istat_reg & ~hwdata[1:0];
      end
      if (alarm_hit) begin
        istat_reg[FLG_ALARM] <= 1'b1;
      end
      if (timer_tick) begin
        istat_reg[FLG_TIMER] <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      imask_reg <= REG_RST[1:0];
    end else if (wr_en_reg && wr_addr_reg == OFS_IMASK) begin
      imask_reg <= hwdata[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat_reg & imask_reg);
    end
  end

  // ****************************************
  // Alarm request pin
  // ****************************************
  // Open drain: the driven level is always low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_request_pin_o <= 1'b0;
      alarm_request_pin_oe <= 1'b0;
    end else begin
      alarm_request_pin_o <= 1'b0;
      alarm_request_pin_oe <= alarm_irq_enable & flag_next[FLG_ALARM];
    end
  end

  // ****************************************
  // Timer request pin
  // ****************************************
  // Auto-return width follows the timer source
  always_comb begin
    rtn_if.load = periodic & timer_irq_enable & timer_tick;
    if (src == SRC_4096) begin
      rtn_if.count = CNT_W'(RTN_FAST_CYC - 1);
    end else begin
      rtn_if.count = CNT_W'(RTN_SLOW_CYC - 1);
    end
  end

  rtcit_countdown u_rtn (
    .hclk(hclk),
    .hresetn(hresetn),
    .c(rtn_if.cnt)
  );

  // Periodic pulse ignores the flag; level follows it
  always_comb begin
    if (!timer_irq_enable) begin
      trq_next = 1'b0;
    end else if (periodic) begin
      trq_next = rtn_if.load | (rtn_if.busy & ~rtn_if.done);
    end else begin
      trq_next = flag_next[FLG_TIMER];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_request_pin_o <= 1'b0;
      timer_request_pin_oe <= 1'b0;
    end else begin
      timer_request_pin_o <= 1'b0;
      timer_request_pin_oe <= trq_next;
    end
  end

  // ****************************************
  // Trim test output
  // ****************************************
  // Trim also needs its enable and the high enable, with or without bypass
  assign test_on = ~cel_n & ceh & ctrl_reg[CTRL_TEST] &
                   ctrl_reg[CTRL_TEN] &
                   (ceh | ctrl_reg[CTRL_BYP]);

  // Positive codes lead, so they shorten each half period
  assign trim_s = {trim_reg[6], trim_reg};
  assign adj = (CNT_W+1)'((trim_s * TRIM_STEP_X4) >>> 2);

  always_comb begin
    tst_fire = test_on & ~tst_if.busy;
    tst_if.load = tst_fire;
    tst_if.count = CNT_W'(TEST_HALF_CYC - 1 - int'(adj));
  end

  rtcit_countdown u_tst (
    .hclk(hclk),
    .hresetn(hresetn),
    .c(tst_if.cnt)
  );

  // Output only when selected and enabled, else undriven
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      freq_output_pin_o <= 1'b0;
      freq_output_pin_oe <= 1'b0;
    end else begin
      freq_output_pin_oe <= test_on & fsel & ctrl_reg[CTRL_FE];
      if (!test_on) begin
        freq_output_pin_o <= 1'b0;
      end else if (tst_fire) begin
        freq_output_pin_o <= ~freq_output_pin_o;
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/rtcit_checker.sv
`timescale 1ns/1ns
`default_nettype none
module rtcit_checker #(
  parameter int RTN_FAST_CYC = 10,
  parameter int RTN_SLOW_CYC = 40,
  parameter int TEST_HALF_CYC = 2000
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus and events
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic sec_carry,
  input wire logic timer_tick,
  input wire logic chip_enable_low_pin_n,
  // Pins
  input wire logic alarm_request_pin_o,
  input wire logic alarm_request_pin_oe,
  input wire logic timer_request_pin_o,
  input wire logic timer_request_pin_oe,
  input wire logic freq_output_pin_o,
  input wire logic freq_output_pin_oe
);
  logic wr_q;
  logic fo_q;
  logic [19:0] hi_cnt;
  logic [19:0] gap_cnt;

  // ****************************************
  // Helpers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      fo_q <= 1'b0;
      hi_cnt <= 20'h0;
      gap_cnt <= 20'h0;
    end else begin
      wr_q <= hsel & htrans[1] & hready & hwrite;
      fo_q <= freq_output_pin_o;
      hi_cnt <= timer_request_pin_oe ? hi_cnt + 20'h1 : 20'h0;
      gap_cnt <= (freq_output_pin_o != fo_q) ? 20'h1 : gap_cnt + 20'h1;
    end
  end

  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ****************************************
  // Assertions
  // ****************************************
  alarm_low_a: assert property (alarm_request_pin_o == 1'b0)
    else $error("alarm request driven high");
  timer_low_a: assert property (timer_request_pin_o == 1'b0)
    else $error("timer request driven high");
  // Flag writes land one edge after the address edge, control writes two
  alarm_on_carry_a: assert property ($rose(alarm_request_pin_oe) |->
    $past(sec_carry) || $past(wr_q, 2))
    else $error("alarm request without carry or write");
  timer_on_tick_a: assert property ($rose(timer_request_pin_oe) |->
    $past(timer_tick) || $past(wr_q, 2))
    else $error("timer request without tick or write");
  alarm_sticky_a: assert property ($fell(alarm_request_pin_oe) |->
    $past(wr_q) || $past(wr_q, 2))
    else $error("alarm request released without write");
  pulse_len_a: assert property ($fell(timer_request_pin_oe) |->
    $past(wr_q) || $past(wr_q, 2) || hi_cnt == RTN_FAST_CYC ||
    hi_cnt == RTN_SLOW_CYC)
    else $error("timer pulse length wrong");
  test_half_a: assert property ($changed(freq_output_pin_o) &&
    freq_output_pin_oe && $past(freq_output_pin_oe) |->
    gap_cnt >= TEST_HALF_CYC / 2)
    else $error("test clock toggles too soon");
  test_exit_a: assert property ($rose(chip_enable_low_pin_n) |->
    ##[1:6] !freq_output_pin_oe)
    else $error("test output kept after enable rose");
endmodule

bind rtcit_top rtcit_checker #(
  .RTN_FAST_CYC(RTN_FAST_CYC),
  .RTN_SLOW_CYC(RTN_SLOW_CYC),
  .TEST_HALF_CYC(TEST_HALF_CYC)
) rtcit_checker_i (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .sec_carry, .timer_tick, .chip_enable_low_pin_n, .alarm_request_pin_o,
  .alarm_request_pin_oe, .timer_request_pin_o, .timer_request_pin_oe,
  .freq_output_pin_o, .freq_output_pin_oe);
`default_nettype wire

// file: verification/rtcit_clock_model.sv
`timescale 1ns/1ns
`default_nettype none
module rtcit_clock_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bench requests
  input wire logic ld,
  input wire logic [28:0] ld_val,
  input wire logic carry_go,
  input wire logic tick_go,
  // Counter side
  output logic [6:0] time_sec,
  output logic [6:0] time_min,
  output logic [5:0] time_hour,
  output logic [2:0] time_wday,
  output logic [5:0] time_day,
  output logic sec_carry,
  output logic timer_tick
);
  // Carry and tick are single-cycle pulses, as real counters give
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {time_day, time_wday, time_hour, time_min, time_sec} <= 29'h0;
      sec_carry <= 1'h0;
      timer_tick <= 1'h0;
    end else begin
      if (ld)
        {time_day, time_wday, time_hour, time_min, time_sec} <= ld_val;
      sec_carry <= carry_go;
      timer_tick <= tick_go;
    end
  end
endmodule
`default_nettype wire

// file: verification/rtcit_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module rtcit_top_tb;
  import rtcit_pkg::*;
  localparam int HALF = 2000;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, irq, ld = 1'b0, carry_go = 1'b0, tick_go = 1'b0;
  logic [28:0] ld_val = 29'h0;
  logic [6:0] time_sec, time_min;
  logic [5:0] time_hour, time_day;
  logic [2:0] time_wday;
  logic sec_carry, timer_tick, ce_lo_n = 1'b1, ce_hi = 1'b0, osel = 1'b1;
  logic alarm_request_pin_o, alarm_request_pin_oe, timer_request_pin_o;
  logic timer_request_pin_oe, freq_output_pin_o, freq_output_pin_oe;
  int error_cnt = 0, cmp_count = 0, n, h0, h1;

  always #10 hclk = ~hclk;

  rtcit_top #(.RTN_FAST_CYC(10), .RTN_SLOW_CYC(40), .TEST_HALF_CYC(HALF))
  rtcit_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .time_sec, .time_min, .time_hour, .time_wday, .time_day, .sec_carry,
    .timer_tick, .chip_enable_low_pin_n(ce_lo_n),
    .chip_enable_high_pin(ce_hi), .output_select_pin(osel),
    .alarm_request_pin_o, .alarm_request_pin_oe, .timer_request_pin_o,
    .timer_request_pin_oe, .freq_output_pin_o, .freq_output_pin_oe, .irq);

  rtcit_clock_model rtcit_clock_model_i (.hclk, .hresetn, .ld, .ld_val,
    .carry_go, .tick_go, .time_sec, .time_min, .time_hour, .time_wday,
    .time_day, .sec_carry, .timer_tick);

  // ****************************************
  // Tasks
  // ****************************************
  task automatic end_sim;
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One idle edge first keeps write and read-back apart
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge hclk);
    @(negedge hclk);
  endtask

  task automatic go(input logic c, input logic t);
    @(posedge hclk);
    carry_go <= c;
    tick_go <= t;
    @(posedge hclk);
    carry_go <= 1'b0;
    tick_go <= 1'b0;
    cyc(1);
  endtask

  task automatic ldt(input logic [28:0] v);
    @(posedge hclk);
    ld <= 1'b1;
    ld_val <= v;
    @(posedge hclk);
    ld <= 1'b0;
  endtask

  task automatic half(output int h);
    logic v;
    @(negedge hclk);
    v = freq_output_pin_o;
    while (freq_output_pin_o === v) @(negedge hclk);
    h = 0;
    v = freq_output_pin_o;
    while (freq_output_pin_o === v) begin
      h++;
      @(negedge hclk);
    end
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(0, OFS_CTRL, 0);
    chk("ctrl reset", rd, REG_RST);
    chk("alarm oe reset", alarm_request_pin_oe, 0);
    xfer(1, OFS_CTRL, 0);
    xfer(1, OFS_FLAGS, 0);
    xfer(1, OFS_ALM0, 32'h0718_0059);
    xfer(0, OFS_ALM0, 0);
    chk("weekday wrap", rd, 32'h0018_0059);
    xfer(1, OFS_ALM1, 32'h0000_0F00);
    ldt({6'h12, 3'h0, 6'h18, 7'h00, 7'h59});
    xfer(0, OFS_TIME0, 0);
    chk("time fields", rd, 32'h0018_0059);
    xfer(1, OFS_FLAGS, 0);
    xfer(0, OFS_FLAGS, 0);
    chk("flag before carry", rd, 0);
    go(1, 0);
    chk("alarm oe masked", alarm_request_pin_oe, 0);
    xfer(0, OFS_FLAGS, 0);
    chk("alarm flag polled", rd, 1);
    xfer(1, OFS_CTRL, 1);
    cyc(1);
    chk("alarm oe", alarm_request_pin_oe, 1);
    xfer(1, OFS_FLAGS, 0);
    cyc(0);
    chk("alarm oe cleared", alarm_request_pin_oe, 0);
    ldt({6'h12, 3'h6, 6'h18, 7'h00, 7'h59});
    go(1, 0);
    chk("weekday miss", alarm_request_pin_oe, 0);
    ldt({6'h12, 3'h0, 6'h18, 7'h00, 7'h59});
    go(1, 0);
    chk("rearmed hit", alarm_request_pin_oe, 1);
    xfer(1, OFS_CTRL, 32'h2);
    xfer(1, OFS_FLAGS, 0);
    go(0, 1);
    cyc(50);
    chk("level held", timer_request_pin_oe, 1);
    xfer(1, OFS_FLAGS, 32'h1);
    cyc(0);
    chk("level released", timer_request_pin_oe, 0);
    xfer(1, OFS_CTRL, 0);
    go(0, 1);
    chk("timer oe off", timer_request_pin_oe, 0);
    for (int s = 0; s < 4; s++) begin
      xfer(1, OFS_CTRL, 32'h6 | (s << 8));
      go(0, 1);
      n = 0;
      while (timer_request_pin_oe === 1'b1 && n < 1000) begin
        n++;
        @(negedge hclk);
      end
      chk("pulse length", n, (s == 0) ? 10 : 40);
    end
    xfer(1, OFS_CTRL, 32'h4);
    xfer(1, OFS_FLAGS, 0);
    go(0, 1);
    chk("periodic off", timer_request_pin_oe, 0);
    xfer(0, OFS_FLAGS, 0);
    chk("periodic flag", rd, 2);
    // Interrupt status, mask and unmapped place
    chk("irq masked", irq, 0);
    xfer(1, OFS_IMASK, 2);
    cyc(2);
    chk("irq raised", irq, 1);
    xfer(1, OFS_ISTAT, 2);
    cyc(2);
    chk("irq cleared", irq, 0);
    xfer(0, OFS_ISTAT, 0);
    chk("istat left", rd, 1);
    xfer(1, 8'h40, 32'hFFFF_FFFF);
    xfer(0, 8'h40, 0);
    chk("unmapped", rd, 0);
    chk("bus okay", hresp, 0);
    @(posedge hclk);
    ce_hi <= 1'b1;
    ce_lo_n <= 1'b0;
    xfer(1, OFS_TRIM, 0);
    xfer(1, OFS_CTRL, 32'h38);
    xfer(1, OFS_CTRL, 32'h78);
    cyc(8);
    chk("test oe", freq_output_pin_oe, 1);
    half(h0);
    half(h0);
    chk("half period", h0 >= HALF && h0 <= HALF + 2, 1);
    xfer(1, OFS_TRIM, 4);
    half(h1);
    half(h1);
    chk("trim shift", h0 - h1 >= 304 && h0 - h1 <= 306, 1);
    @(posedge hclk);
    ce_lo_n <= 1'b1;
    cyc(8);
    chk("test exit oe", freq_output_pin_oe, 0);
    xfer(0, OFS_CTRL, 0);
    chk("test bit cleared", rd, 32'h38);
    end_sim;
  end

  initial begin
    #(20 * 40000);
    error_cnt++;
    end_sim;
  end
endmodule
`default_nettype wire
